/* mlprs_pkg.sv */
// Purpose: Shared constants and types for the low-power and reset pin states
// Assumes: One 250 MHz clock, asynchronous active-low reset
// Notes:   All pin enables are active low (low while the pin is driven)

package mlprs_pkg;

   // ---------------------------------------------------------------------
   // Widths and constant values
   // ---------------------------------------------------------------------
   localparam int         P2_W          = 5;
   localparam int         BYTE_W        = 8;
   localparam int         ADDR_W        = 16;
   localparam logic [7:0] ONES_8        = 8'hff;
   localparam logic [4:0] ONES_5        = 5'h1f;
   localparam logic [7:0] WO_READ_VALUE = 8'hff;
   localparam logic       DRIVE         = 1'h0;
   localparam logic       FLOAT         = 1'h1;
   localparam logic       LEVEL_HIGH    = 1'h1;
   localparam int         HI_LSB        = 8;

   // ---------------------------------------------------------------------
   // Power state, Gray coded along reset-active-sleep and on to standby
   // ---------------------------------------------------------------------
   typedef enum logic [1:0] {
      MLPRS_RESET   = 2'h0,
      MLPRS_ACTIVE  = 2'h1,
      MLPRS_SLEEP   = 2'h3,
      MLPRS_STANDBY = 2'h2
   } mlprs_state_t;

   // ---------------------------------------------------------------------
   // All state of the block
   // ---------------------------------------------------------------------
   typedef struct packed {
      mlprs_state_t state;
      logic         ers_s1;
      logic         ers_s2;
      logic         stb_s1;
      logic         stb_s2;
      logic         osc_s1;
      logic         osc_s2;
      logic [4:0]   hold_p2_val;
      logic [4:0]   hold_p2_oe_n;
      logic [7:0]   hold_p1_val;
      logic [7:0]   hold_p1_oe_n;
      logic [4:0]   p2_val;
      logic [4:0]   p2_oe_n;
      logic [7:0]   p1_val;
      logic [7:0]   p1_oe_n;
      logic [7:0]   hi_val;
      logic         hi_oe_n;
      logic [7:0]   ad_val;
      logic         ad_oe_n;
      logic         rw_val;
      logic         rw_oe_n;
      logic         as_val;
      logic         as_oe_n;
      logic [7:0]   rdata;
      logic         wake_vector;
      logic         wake_resume;
   } mlprs_regs_t;

   localparam mlprs_regs_t REGS_RST = '{
      state: MLPRS_RESET, ers_s1: 1'h0, ers_s2: 1'h0, stb_s1: 1'h1,
      stb_s2: 1'h1, osc_s1: 1'h0, osc_s2: 1'h0,
      hold_p2_val: 5'h0, hold_p2_oe_n: 5'h1f,
      hold_p1_val: 8'h0, hold_p1_oe_n: 8'hff,
      p2_val: 5'h0, p2_oe_n: 5'h1f, p1_val: 8'h0, p1_oe_n: 8'hff,
      hi_val: 8'h0, hi_oe_n: 1'h1, ad_val: 8'h0, ad_oe_n: 1'h1,
      rw_val: 1'h1, rw_oe_n: 1'h1, as_val: 1'h0, as_oe_n: 1'h1,
      rdata: 8'h0, wake_vector: 1'h0, wake_resume: 1'h0
   };

endpackage : mlprs_pkg

/* mlprs_pin_states.sv */
// Purpose: Power state control and pin state selection for sleep, standby
//          and reset, in non-multiplexed and multiplexed bus modes
// Assumes: Core, bus phase and interrupt inputs are on clock_in; reset,
//          standby and oscillator-good come from outside and are synced
// Notes:   Pins except the crystal output change on the same clock as the state (registered outputs)
//
// Contract
// - Standby keeps only supply and standby input working; other pins except the crystal output float.
// - Standby ignores the crystal input and drives the crystal output high.
// - Non-multiplexed sleep: port 2 held, address and read/write high.
// - Multiplexed sleep: port 1 held, upper address and strobe live.
// - Non-multiplexed reset: ports and buses float, read/write high, strobe phased.
// - Multiplexed reset: shared address/data lines driven high in both phases.
// - A write-only register always reads back as all ones.
// - External reset is sampled on the internal clock, never asynchronously.
// - External reset has no effect until the oscillator has started.
// - Sleep halts the core, keeps registers, peripherals keep running.
// - Sleep ends on interrupt, reset or standby; masked resumes after sleep.
// - Standby request resets the core, stops clocks; left only by reset start.

`timescale 1ns/1ns
`default_nettype none

module mlprs_pin_states (
   input  wire logic       clock_in,
   input  wire logic       arst_n_in,
   input  wire logic       external_reset_n_in,
   input  wire logic       standby_request_n_in,
   input  wire logic       osc_running_in,
   input  wire logic       crystal_input_in,
   input  wire logic       mux_mode_in,
   input  wire logic       bus_phase_e_in,
   input  wire logic       sleep_instruction_in,
   input  wire logic       irq_request_in,
   input  wire logic       irq_masked_in,
   input  wire logic [15:0] core_addr_in,
   input  wire logic [7:0] core_wdata_in,
   input  wire logic       core_wdrive_in,
   input  wire logic       core_rw_in,
   input  wire logic       core_as_in,
   input  wire logic [4:0] core_p2_val_in,
   input  wire logic [4:0] core_p2_dir_in,
   input  wire logic [7:0] core_p1_val_in,
   input  wire logic [7:0] core_p1_dir_in,
   input  wire logic       wo_read_in,
   input  wire logic [7:0] reg_rdata_in,
   output logic [4:0]      port2_lines_out,
   output logic [4:0]      port2_lines_oe_n_out,
   output logic [7:0]      port1_lines_out,
   output logic [7:0]      port1_lines_oe_n_out,
   output logic [7:0]      addr_hi_out,
   output logic            addr_hi_oe_n_out,
   output logic [7:0]      addr_data_out,
   output logic            addr_data_oe_n_out,
   output logic            rw_out,
   output logic            rw_oe_n_out,
   output logic            address_strobe_out,
   output logic            address_strobe_oe_n_out,
   output logic            crystal_output_out,
   output logic            core_reset_out,
   output logic            core_halt_out,
   output logic            clocks_run_out,
   output logic            wake_vector_out,
   output logic            wake_resume_out,
   output logic [7:0]      rdata_out
);

   mlprs_pkg::mlprs_regs_t st;
   mlprs_pkg::mlprs_regs_t next_st;
   logic                   rst_req;
   logic                   standby_request_n_req;
   logic                   ph_e;

   // ---------------------------------------------------------------------
   // Next state and pin selection
   // ---------------------------------------------------------------------
   always_comb begin
      next_st        = st;
      next_st.ers_s1 = external_reset_n_in;
      next_st.ers_s2 = st.ers_s1;
      next_st.stb_s1 = standby_request_n_in;
      next_st.stb_s2 = st.stb_s1;
      next_st.osc_s1 = osc_running_in;
      next_st.osc_s2 = st.osc_s1;
      ph_e           = bus_phase_e_in;
      // Reset is blind until the oscillator is seen running
      rst_req  = !st.ers_s2 && st.osc_s2;
      standby_request_n_req = !st.stb_s2;
      next_st.wake_vector = 1'h0;
      next_st.wake_resume = 1'h0;
      next_st.rdata = wo_read_in ? mlprs_pkg::WO_READ_VALUE
                                 : reg_rdata_in;

      // Standby wins over everything, reset over sleep
      if (standby_request_n_req) begin
         next_st.state = mlprs_pkg::MLPRS_STANDBY;
      end else begin
         case (st.state)
            mlprs_pkg::MLPRS_STANDBY: begin
               // Only a reset start leaves standby
               if (rst_req) begin
                  next_st.state = mlprs_pkg::MLPRS_RESET;
               end
            end
            mlprs_pkg::MLPRS_RESET: begin
               if (st.ers_s2 && st.osc_s2) begin
                  next_st.state = mlprs_pkg::MLPRS_ACTIVE;
               end
            end
            mlprs_pkg::MLPRS_ACTIVE: begin
               if (rst_req) begin
                  next_st.state = mlprs_pkg::MLPRS_RESET;
               end else if (sleep_instruction_in) begin
                  next_st.state        = mlprs_pkg::MLPRS_SLEEP;
                  next_st.hold_p2_val  = core_p2_val_in;
                  next_st.hold_p2_oe_n = ~core_p2_dir_in;
                  next_st.hold_p1_val  = core_p1_val_in;
                  next_st.hold_p1_oe_n = ~core_p1_dir_in;
               end
            end
            mlprs_pkg::MLPRS_SLEEP: begin
               if (rst_req) begin
                  next_st.state = mlprs_pkg::MLPRS_RESET;
               end else if (irq_request_in) begin
                  next_st.state       = mlprs_pkg::MLPRS_ACTIVE;
                  next_st.wake_vector = !irq_masked_in;
                  next_st.wake_resume = irq_masked_in;
               end
            end
            default: begin
               next_st.state = mlprs_pkg::MLPRS_RESET;
            end
         endcase
      end

      // Pins: operating values first, then overridden per state
      next_st.p2_val  = core_p2_val_in;
      next_st.p2_oe_n = ~core_p2_dir_in;
      next_st.hi_val  = core_addr_in[mlprs_pkg::HI_LSB +: mlprs_pkg::BYTE_W];
      next_st.hi_oe_n = mlprs_pkg::DRIVE;
      next_st.rw_val  = core_rw_in;
      next_st.rw_oe_n = mlprs_pkg::DRIVE;
      next_st.as_val  = core_as_in;
      next_st.as_oe_n = mlprs_pkg::DRIVE;
      if (mux_mode_in) begin
         next_st.p1_val  = core_p1_val_in;
         next_st.p1_oe_n = ~core_p1_dir_in;
         next_st.ad_val  = ph_e ? core_wdata_in
                                : core_addr_in[mlprs_pkg::BYTE_W-1:0];
         next_st.ad_oe_n = (ph_e && !core_wdrive_in) ? mlprs_pkg::FLOAT
                                                     : mlprs_pkg::DRIVE;
      end else begin
         next_st.p1_val  = core_addr_in[mlprs_pkg::BYTE_W-1:0];
         next_st.p1_oe_n = {mlprs_pkg::BYTE_W{mlprs_pkg::DRIVE}};
         next_st.ad_val  = core_wdata_in;
         next_st.ad_oe_n = core_wdrive_in ? mlprs_pkg::DRIVE
                                          : mlprs_pkg::FLOAT;
      end

      case (next_st.state)
         mlprs_pkg::MLPRS_SLEEP: begin
            next_st.p2_val  = next_st.hold_p2_val;
            next_st.p2_oe_n = next_st.hold_p2_oe_n;
            next_st.rw_val  = mlprs_pkg::LEVEL_HIGH;
            if (mux_mode_in) begin
               next_st.p1_val  = next_st.hold_p1_val;
               next_st.p1_oe_n = next_st.hold_p1_oe_n;
               next_st.ad_val  = mlprs_pkg::ONES_8;
               next_st.ad_oe_n = ph_e ? mlprs_pkg::FLOAT
                                      : mlprs_pkg::DRIVE;
            end else begin
               next_st.p1_val  = mlprs_pkg::ONES_8;
               next_st.hi_val  = mlprs_pkg::ONES_8;
               next_st.ad_oe_n = mlprs_pkg::FLOAT;
            end
         end
         mlprs_pkg::MLPRS_RESET: begin
            next_st.p2_oe_n = mlprs_pkg::ONES_5;
            next_st.p1_oe_n = mlprs_pkg::ONES_8;
            next_st.hi_oe_n = mlprs_pkg::FLOAT;
            next_st.rw_val  = mlprs_pkg::LEVEL_HIGH;
            next_st.as_val  = mlprs_pkg::LEVEL_HIGH;
            next_st.as_oe_n = ph_e ? mlprs_pkg::FLOAT : mlprs_pkg::DRIVE;
            next_st.ad_val  = mlprs_pkg::ONES_8;
            // Multiplexed: high in both phases, memory must stay off
            next_st.ad_oe_n = mux_mode_in ? mlprs_pkg::DRIVE
                                          : mlprs_pkg::FLOAT;
         end
         mlprs_pkg::MLPRS_STANDBY: begin
            next_st.p2_oe_n = mlprs_pkg::ONES_5;
            next_st.p1_oe_n = mlprs_pkg::ONES_8;
            next_st.hi_oe_n = mlprs_pkg::FLOAT;
            next_st.ad_oe_n = mlprs_pkg::FLOAT;
            next_st.rw_oe_n = mlprs_pkg::FLOAT;
            next_st.as_oe_n = mlprs_pkg::FLOAT;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st <= mlprs_pkg::REGS_RST;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   assign port2_lines_out         = st.p2_val;
   assign port2_lines_oe_n_out    = st.p2_oe_n;
   assign port1_lines_out         = st.p1_val;
   assign port1_lines_oe_n_out    = st.p1_oe_n;
   assign addr_hi_out             = st.hi_val;
   assign addr_hi_oe_n_out        = st.hi_oe_n;
   assign addr_data_out           = st.ad_val;
   assign addr_data_oe_n_out      = st.ad_oe_n;
   assign rw_out                  = st.rw_val;
   assign rw_oe_n_out             = st.rw_oe_n;
   assign address_strobe_out      = st.as_val;
   assign address_strobe_oe_n_out = st.as_oe_n;
   assign rdata_out               = st.rdata;
   assign wake_vector_out         = st.wake_vector;
   assign wake_resume_out         = st.wake_resume;
   // Crystal path is a gate, not a flop: the oscillator cannot wait a clock
   assign crystal_output_out = (st.state == mlprs_pkg::MLPRS_STANDBY) ?
                               mlprs_pkg::LEVEL_HIGH : !crystal_input_in;
   assign core_reset_out = (st.state == mlprs_pkg::MLPRS_RESET) ||
                           (st.state == mlprs_pkg::MLPRS_STANDBY);
   assign core_halt_out  = (st.state == mlprs_pkg::MLPRS_SLEEP);
   assign clocks_run_out = (st.state != mlprs_pkg::MLPRS_STANDBY);

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);

   AST_STANDBY_FLOAT: assert property (
      st.state == mlprs_pkg::MLPRS_STANDBY && next_st.state == st.state
      |=> (&port2_lines_oe_n_out) && (&port1_lines_oe_n_out) &&
          addr_hi_oe_n_out && addr_data_oe_n_out && rw_oe_n_out &&
          address_strobe_oe_n_out)
      else $error("Pin driven in standby");
   AST_CRYSTAL_OUTPUT_HIGH: assert property (
      st.state == mlprs_pkg::MLPRS_STANDBY |-> crystal_output_out)
      else $error("Crystal output not high in standby");
   AST_SLEEP_NONMUX: assert property (
      next_st.state == mlprs_pkg::MLPRS_SLEEP && !mux_mode_in
      |=> addr_hi_out == 8'hff && port1_lines_out == 8'hff &&
          rw_out && !rw_oe_n_out && addr_data_oe_n_out)
      else $error("Non-mux sleep pins wrong");
   AST_SLEEP_MUX: assert property (
      next_st.state == mlprs_pkg::MLPRS_SLEEP && mux_mode_in &&
      !bus_phase_e_in
      |=> addr_data_out == 8'hff && !addr_data_oe_n_out &&
          port1_lines_out == st.hold_p1_val &&
          port1_lines_oe_n_out == st.hold_p1_oe_n)
      else $error("Mux sleep pins wrong");
   AST_RESET_NONMUX: assert property (
      next_st.state == mlprs_pkg::MLPRS_RESET && !mux_mode_in &&
      bus_phase_e_in
      |=> rw_out && !rw_oe_n_out && address_strobe_oe_n_out &&
          addr_data_oe_n_out && addr_hi_oe_n_out)
      else $error("Non-mux reset pins wrong");
   AST_RESET_MUX: assert property (
      next_st.state == mlprs_pkg::MLPRS_RESET && mux_mode_in
      |=> addr_data_out == 8'hff && !addr_data_oe_n_out)
      else $error("Mux reset lines not driven high");
   AST_WO_READ: assert property (
      wo_read_in |=> rdata_out == 8'hff)
      else $error("Write-only read not all ones");
   AST_RESET_SYNC: assert property (
      $fell(external_reset_n_in) && standby_request_n_in &&
      st.osc_s2 && st.state == mlprs_pkg::MLPRS_ACTIVE
      |=> !core_reset_out)
      else $error("Reset acted without synchronising");
   AST_NO_OSC: assert property (
      !st.osc_s2 && st.state == mlprs_pkg::MLPRS_ACTIVE &&
      standby_request_n_in && st.stb_s2
      |=> st.state != mlprs_pkg::MLPRS_RESET)
      else $error("Reset effective before oscillator");
   AST_SLEEP_ENTRY: assert property (
      st.state == mlprs_pkg::MLPRS_ACTIVE && sleep_instruction_in &&
      st.ers_s2 && st.stb_s2
      |=> core_halt_out && clocks_run_out)
      else $error("Sleep did not halt core");
   AST_MASKED_WAKE: assert property (
      st.state == mlprs_pkg::MLPRS_SLEEP && irq_request_in &&
      irq_masked_in && !rst_req && st.stb_s2
      |=> wake_resume_out && !wake_vector_out && !core_halt_out)
      else $error("Masked wake wrong");
   AST_STANDBY_EXIT: assert property (
      st.state == mlprs_pkg::MLPRS_STANDBY
      |=> st.state == mlprs_pkg::MLPRS_STANDBY ||
          st.state == mlprs_pkg::MLPRS_RESET)
      else $error("Standby left without reset start");

endmodule : mlprs_pin_states

`default_nettype wire

/* mlprs_ext_mem.sv */
// Purpose: Model of external memory on the multiplexed expanded bus
// Assumes: Board reset is the AND of power-on and external reset
// Notes:   Reads only; released lines show the inverse of the last byte

`timescale 1ns/1ns
`default_nettype none

module mlprs_ext_mem (
   input  wire logic       clock_in,
   input  wire logic       sys_reset_n_in,
   input  wire logic       strobe_in,
   input  wire logic       e_phase_in,
   input  wire logic       rw_in,
   input  wire logic [7:0] ad_in,
   output logic [7:0]      mem_data_out,
   output logic            mem_oe_n_out,
   output logic [7:0]      latched_addr_out
);
   logic [7:0] mem [0:255];
   logic [7:0] last    = 8'h00;
   logic [7:0] latch_q = 8'h00;

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
   end

   // ---------------------------------------------------------------------
   // Address latch and read drive
   // ---------------------------------------------------------------------
   always @(negedge strobe_in) begin
      latch_q <= ad_in;
   end

   assign latched_addr_out = latch_q;

   // Held off through all of reset, else it fights the driven-high lines
   assign mem_oe_n_out = ~(sys_reset_n_in & e_phase_in & rw_in);

   always @(posedge clock_in) begin
      if (!mem_oe_n_out) begin
         last <= mem[latch_q];
      end
   end

   // A stale copy would hide a missing drive, so show the inverse
   assign mem_data_out = mem_oe_n_out ? ~last : mem[latch_q];

endmodule : mlprs_ext_mem

`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the low-power and reset pin states
// Assumes: Inputs change at the falling edge; pins checked there too
// Notes:   Pins other than the crystal output are registered, so each check waits past one rising edge

`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) chk(nm, 16'(e), 16'(g))

module tb;
   logic        clock_in = 1'h0;
   logic        arst_n_in, external_reset_n_in, standby_request_n_in;
   logic        osc_running_in, crystal_input_in, mux_mode_in;
   logic        bus_phase_e_in, sleep_instruction_in, irq_request_in;
   logic        irq_masked_in, core_wdrive_in, core_rw_in, core_as_in;
   logic        wo_read_in;
   logic [15:0] core_addr_in;
   logic [7:0]  core_wdata_in, core_p1_val_in, core_p1_dir_in, reg_rdata_in;
   logic [4:0]  core_p2_val_in, core_p2_dir_in;
   logic [4:0]  port2_lines_out, port2_lines_oe_n_out;
   logic [7:0]  port1_lines_out, port1_lines_oe_n_out, addr_hi_out;
   logic [7:0]  addr_data_out, rdata_out, mem_data, latched;
   logic        addr_hi_oe_n_out, addr_data_oe_n_out, rw_out, rw_oe_n_out;
   logic        address_strobe_out, address_strobe_oe_n_out;
   logic        crystal_output_out, core_reset_out, core_halt_out;
   logic        clocks_run_out, wake_vector_out, wake_resume_out, mem_oe_n;
   logic [7:0]  ad_bus;
   logic        strobe_bus, rw_bus;
   int          fails = 0;
   int          n_compared = 0;
   int          cyc = 0;

   always #2 clock_in = ~clock_in;

   // Strobe has a pull-down, read/write a pull-up
   assign strobe_bus = address_strobe_oe_n_out ? 1'h0 : address_strobe_out;
   assign rw_bus     = rw_oe_n_out ? 1'h1 : rw_out;
   assign ad_bus     = addr_data_oe_n_out ? mem_data : addr_data_out;

   mlprs_pin_states u_mlprs_pin_states (
      .clock_in, .arst_n_in, .external_reset_n_in, .standby_request_n_in,
      .osc_running_in, .crystal_input_in, .mux_mode_in, .bus_phase_e_in,
      .sleep_instruction_in, .irq_request_in, .irq_masked_in, .core_addr_in,
      .core_wdata_in, .core_wdrive_in, .core_rw_in, .core_as_in,
      .core_p2_val_in, .core_p2_dir_in, .core_p1_val_in, .core_p1_dir_in,
      .wo_read_in, .reg_rdata_in, .port2_lines_out, .port2_lines_oe_n_out,
      .port1_lines_out, .port1_lines_oe_n_out, .addr_hi_out,
      .addr_hi_oe_n_out, .addr_data_out, .addr_data_oe_n_out, .rw_out,
      .rw_oe_n_out, .address_strobe_out, .address_strobe_oe_n_out,
      .crystal_output_out, .core_reset_out, .core_halt_out, .clocks_run_out,
      .wake_vector_out, .wake_resume_out, .rdata_out);

   mlprs_ext_mem u_mlprs_ext_mem (
      .clock_in(clock_in), .sys_reset_n_in(arst_n_in & external_reset_n_in),
      .strobe_in(strobe_bus), .e_phase_in(bus_phase_e_in), .rw_in(rw_bus),
      .ad_in(ad_bus), .mem_data_out(mem_data), .mem_oe_n_out(mem_oe_n),
      .latched_addr_out(latched));

   // ---------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(negedge clock_in);
   endtask : step

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_compared++;
      if (e !== g) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic ports_float();
      `CHK("p2_oe_n", 5'h1f, port2_lines_oe_n_out);
      `CHK("p1_oe_n", 8'hff, port1_lines_oe_n_out);
      `CHK("hi_oe_n", 1'h1, addr_hi_oe_n_out);
   endtask : ports_float

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   // Whole run is about 60 cycles
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         close_out();
      end
   end

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_reset_nonmux();
      mux_mode_in = 1'h0;
      bus_phase_e_in = 1'h0;
      step(1);
      ports_float();
      `CHK("ad_oe_n", 1'h1, addr_data_oe_n_out);
      `CHK("rw", 2'h1, {rw_oe_n_out, rw_out});
      `CHK("as e low", 2'h1, {address_strobe_oe_n_out, address_strobe_out});
      bus_phase_e_in = 1'h1;
      step(1);
      `CHK("as e high", 1'h1, address_strobe_oe_n_out);
      $display("test reset_nonmux done");
   endtask : t_reset_nonmux

   task automatic t_reset_mux();
      mux_mode_in = 1'h1;
      for (int ph = 0; ph < 2; ph++) begin
         bus_phase_e_in = ph[0];
         step(1);
         `CHK("ad", 9'h0ff, {addr_data_oe_n_out, addr_data_out});
         `CHK("mem_oe_n", 1'h1, mem_oe_n);
      end
      $display("test reset_mux done");
   endtask : t_reset_mux

   task automatic t_leave_reset();
      external_reset_n_in = 1'h1;
      step(2);
      `CHK("reset not yet", 1'h1, core_reset_out);
      step(1);
      `CHK("reset left", 1'h0, core_reset_out);
      // Mid-run reset pin pulse: two sync edges pass before it acts
      external_reset_n_in = 1'h0;
      step(2);
      `CHK("reset synced", 1'h0, core_reset_out);
      step(1);
      `CHK("reset taken", 1'h1, core_reset_out);
      external_reset_n_in = 1'h1;
      step(3);
      `CHK("reset left again", 1'h0, core_reset_out);
      $display("test leave_reset done");
   endtask : t_leave_reset

   task automatic t_sleep_nonmux();
      mux_mode_in = 1'h0;
      core_p2_val_in = 5'h15;
      core_p2_dir_in = 5'h0f;
      core_rw_in = 1'h0;
      sleep_instruction_in = 1'h1;
      step(1);
      sleep_instruction_in = 1'h0;
      core_p2_val_in = 5'h0a;
      core_p2_dir_in = 5'h1f;
      step(2);
      `CHK("halt", 2'h3, {core_halt_out, clocks_run_out});
      `CHK("p2 oe_n", 5'h10, port2_lines_oe_n_out);
      `CHK("p2", 5'h05, port2_lines_out & 5'h0f);
      `CHK("hi", 9'h0ff, {addr_hi_oe_n_out, addr_hi_out});
      `CHK("p1", 16'h00ff, {port1_lines_oe_n_out, port1_lines_out});
      `CHK("rw", 2'h1, {rw_oe_n_out, rw_out});
      `CHK("ad_oe_n", 1'h1, addr_data_oe_n_out);
      irq_masked_in = 1'h1;
      irq_request_in = 1'h1;
      step(1);
      irq_request_in = 1'h0;
      `CHK("resume", 3'h4, {wake_resume_out, wake_vector_out, core_halt_out});
      step(1);
      `CHK("resume pulse", 1'h0, wake_resume_out);
      $display("test sleep_nonmux done");
   endtask : t_sleep_nonmux

   task automatic t_sleep_mux();
      mux_mode_in = 1'h1;
      bus_phase_e_in = 1'h0;
      core_p1_val_in = 8'h5a;
      core_p1_dir_in = 8'hf0;
      core_addr_in = 16'hab00;
      core_as_in = 1'h1;
      sleep_instruction_in = 1'h1;
      step(1);
      sleep_instruction_in = 1'h0;
      core_p1_val_in = 8'ha5;
      core_p1_dir_in = 8'hff;
      core_as_in = 1'h0;
      step(2);
      `CHK("p1 oe_n", 8'h0f, port1_lines_oe_n_out);
      `CHK("p1", 8'h50, port1_lines_out & 8'hf0);
      `CHK("hi", 9'h0ab, {addr_hi_oe_n_out, addr_hi_out});
      `CHK("as", 2'h0, {address_strobe_oe_n_out, address_strobe_out});
      `CHK("ad e low", 9'h0ff, {addr_data_oe_n_out, addr_data_out});
      `CHK("latched", 8'hff, latched);
      bus_phase_e_in = 1'h1;
      step(1);
      `CHK("ad e high", 1'h1, addr_data_oe_n_out);
      irq_masked_in = 1'h0;
      irq_request_in = 1'h1;
      step(1);
      irq_request_in = 1'h0;
      `CHK("vector", 3'h2, {wake_resume_out, wake_vector_out, core_halt_out});
      $display("test sleep_mux done");
   endtask : t_sleep_mux

   task automatic t_wo_read();
      reg_rdata_in = 8'h3c;
      wo_read_in = 1'h1;
      step(1);
      wo_read_in = 1'h0;
      `CHK("wo rdata", 8'hff, rdata_out);
      step(1);
      `CHK("plain rdata", 8'h3c, rdata_out);
      $display("test wo_read done");
   endtask : t_wo_read

   task automatic t_standby();
      crystal_input_in = 1'h1;
      standby_request_n_in = 1'h0;
      step(3);
      ports_float();
      `CHK("bus oe_n", 3'h7, {addr_data_oe_n_out, rw_oe_n_out,
           address_strobe_oe_n_out});
      `CHK("clocks", 2'h2, {core_reset_out, clocks_run_out});
      `CHK("crystal_output out", 1'h1, crystal_output_out);
      crystal_input_in = 1'h0;
      standby_request_n_in = 1'h1;
      step(4);
      `CHK("crystal_output fixed", 1'h1, crystal_output_out);
      `CHK("still standby", 1'h0, clocks_run_out);
      external_reset_n_in = 1'h0;
      step(3);
      `CHK("reset start", 2'h3, {core_reset_out, clocks_run_out});
      external_reset_n_in = 1'h1;
      step(3);
      $display("test standby done");
   endtask : t_standby

   task automatic t_osc_gate();
      osc_running_in = 1'h0;
      step(3);
      external_reset_n_in = 1'h0;
      step(4);
      `CHK("no osc reset", 1'h0, core_reset_out);
      osc_running_in = 1'h1;
      step(3);
      `CHK("osc reset", 1'h1, core_reset_out);
      external_reset_n_in = 1'h1;
      step(3);
      $display("test osc_gate done");
   endtask : t_osc_gate

   initial begin
      {arst_n_in, external_reset_n_in, mux_mode_in, bus_phase_e_in} = 4'h0;
      {sleep_instruction_in, irq_request_in, irq_masked_in} = 3'h0;
      {core_wdrive_in, core_rw_in, core_as_in, wo_read_in} = 4'h0;
      {standby_request_n_in, osc_running_in, crystal_input_in} = 3'h6;
      core_addr_in = 16'h0000;
      core_wdata_in = 8'h00;
      {core_p1_val_in, core_p1_dir_in, reg_rdata_in} = 24'h000000;
      {core_p2_val_in, core_p2_dir_in} = 10'h000;
      // Reset source stays low well past start-up
      step(6);
      arst_n_in = 1'h1;
      step(2);
      t_reset_nonmux();
      t_reset_mux();
      t_leave_reset();
      t_sleep_nonmux();
      t_sleep_mux();
      t_wo_read();
      t_standby();
      t_osc_gate();
      close_out();
   end

endmodule : tb

`default_nettype wire
